// ---- design/pmee_top.sv ----
// Port register driving the internal two-wire lines, plus the internal
// serial data store that answers on them. Software bit-bangs the lines.
// Assumes a register port with read data one cycle after the read strobe.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
module pmee_top
  import pmee_pkg::*;
#(
  parameter logic [BUSY_W-1:0] BUSY_CYCLES = BUSY_W'(WRITE_BUSY_CYCLES)
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata_q,
  output logic scl_q,
  output logic sda_oe_n_q,
  output logic store_busy_q
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic sda_line;
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  pmee_phase_t phase_q;
  logic [3:0] bit_cnt_q;
  logic [1:0] byte_idx_q;
  logic [7:0] shift_q;
  logic rw_q, pull_q, wrote_q, busy_start_q;
  logic [STORE_AW-1:0] addr_q;
  logic mem_we_q;
  logic [STORE_AW-1:0] mem_waddr_q;
  logic [7:0] mem_wdata_q, mem_rdata;
  logic [BUSY_W-1:0] busy_cnt_q;
  pmee_port_t rd_port;

  function automatic logic hits_port(input logic [4:0] a);
    return a == PORT_DATA_ADDR;
  endfunction

  // ************************************************************
  // Port register
  // ************************************************************
  // Wired data line: either side pulling low wins, else the pull-up
  assign sda_line = sda_oe_n_q & ~pull_q;
  assign rd_port = '{scl: scl_q, sda: sda_line, gp: GP_READ};

  // Line bits are latched outputs with no direction control
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_q <= LINE_IDLE;
      sda_oe_n_q <= LINE_IDLE;
    end else if (reg_we && hits_port(reg_addr)) begin
      scl_q <= reg_wdata[SCL_BIT];
      sda_oe_n_q <= reg_wdata[SDA_BIT];
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata_q <= READ_ZERO;
    end else if (reg_re && hits_port(reg_addr)) begin
      reg_rdata_q <= rd_port;
    end else begin
      reg_rdata_q <= READ_ZERO;
    end
  end

  // ************************************************************
  // Store side line sampling
  // ************************************************************
  // Two flops then an edge stage; lines never leave the block
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_s1_q <= LINE_IDLE;
      scl_s2_q <= LINE_IDLE;
      scl_s3_q <= LINE_IDLE;
      sda_s1_q <= LINE_IDLE;
      sda_s2_q <= LINE_IDLE;
      sda_s3_q <= LINE_IDLE;
    end else begin
      scl_s1_q <= scl_q;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_line;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  // Data edge with clock high is framing only
  assign start_det = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
  assign stop_det = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;

  // ************************************************************
  // Store protocol engine
  // ************************************************************
  // Samples on clock rise, drives the data line only after clock fall
  always_ff @(posedge clk) begin
    if (srst) begin
      phase_q <= PH_IDLE;
      bit_cnt_q <= '0;
      byte_idx_q <= IDX_CTRL;
      shift_q <= '0;
      rw_q <= 1'b0;
      pull_q <= 1'b0;
      wrote_q <= 1'b0;
      busy_start_q <= 1'b0;
      addr_q <= '0;
      mem_we_q <= 1'b0;
      mem_waddr_q <= '0;
      mem_wdata_q <= '0;
    end else begin
      mem_we_q <= 1'b0;
      busy_start_q <= 1'b0;
      if (stop_det) begin
        phase_q <= PH_IDLE;
        pull_q <= 1'b0;
        busy_start_q <= wrote_q;
        wrote_q <= 1'b0;
      end else if (start_det) begin
        phase_q <= PH_RX;
        bit_cnt_q <= '0;
        byte_idx_q <= IDX_CTRL;
        pull_q <= 1'b0;
      end else begin
        case (phase_q)
          PH_RX: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s2_q};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == BITS_PER_BYTE) begin
              phase_q <= PH_ACK;
              pull_q <= 1'b1;
              if (byte_idx_q == IDX_CTRL) begin
                rw_q <= shift_q[0];
                // Busy store or foreign code: no acknowledge
                if (shift_q[7:4] != DEV_CODE || store_busy_q) begin
                  phase_q <= PH_IDLE;
                  pull_q <= 1'b0;
                end
              end else if (byte_idx_q == IDX_WADDR) begin
                addr_q <= shift_q[STORE_AW-1:0];
              end else begin
                mem_we_q <= 1'b1;
                mem_waddr_q <= addr_q;
                mem_wdata_q <= shift_q;
                addr_q <= addr_q + 1'b1;
                wrote_q <= 1'b1;
              end
            end
          end
          PH_ACK: begin
            if (scl_fall) begin
              bit_cnt_q <= '0;
              if (byte_idx_q == IDX_CTRL && rw_q) begin
                phase_q <= PH_TX;
                shift_q <= mem_rdata;
                pull_q <= ~mem_rdata[7];
              end else begin
                phase_q <= PH_RX;
                pull_q <= 1'b0;
                if (byte_idx_q != IDX_DATA) begin
                  byte_idx_q <= byte_idx_q + 2'h1;
                end
              end
            end
          end
          PH_TX: begin
            if (scl_rise) begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_q == BITS_PER_BYTE) begin
                phase_q <= PH_MACK;
                pull_q <= 1'b0;
                addr_q <= addr_q + 1'b1;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                pull_q <= ~shift_q[6];
              end
            end
          end
          PH_MACK: begin
            // No acknowledge from software ends the read
            if (scl_rise && sda_s2_q) begin
              phase_q <= PH_IDLE;
            end else if (scl_fall) begin
              phase_q <= PH_TX;
              bit_cnt_q <= '0;
              shift_q <= mem_rdata;
              pull_q <= ~mem_rdata[7];
            end
          end
          default: begin
            pull_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Write cycle timer
  // ************************************************************
  // Store refuses new selections while the internal write runs
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_cnt_q <= '0;
      store_busy_q <= 1'b0;
    end else if (busy_start_q) begin
      busy_cnt_q <= BUSY_CYCLES;
      store_busy_q <= 1'b1;
    end else if (busy_cnt_q != '0) begin
      busy_cnt_q <= busy_cnt_q - 1'b1;
      store_busy_q <= busy_cnt_q != BUSY_W'(1);
    end else begin
      store_busy_q <= 1'b0;
    end
  end

  // ************************************************************
  // Data store
  // ************************************************************
  pmee_mem u_mem (
    .clk(clk),
    .we(mem_we_q),
    .waddr(mem_waddr_q),
    .wdata(mem_wdata_q),
    .raddr(addr_q),
    .rdata_q(mem_rdata)
  );

endmodule

// ---- design/pmee_pkg.sv ----
// Package for the port-mapped two-wire data store: register map, field
// positions, reset values, protocol and timing constants, shared types.
// Assumes a 100 MHz core clock and a file-address register port.
package pmee_pkg;

  // ************************************************************
  // Register map and fields
  // ************************************************************
  localparam logic [4:0] PORT_DATA_ADDR = 5'h06;
  localparam int SCL_BIT = 7;
  localparam int SDA_BIT = 6;
  localparam logic LINE_IDLE = 1'h1;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [5:0] GP_READ = 6'h00;

  // ************************************************************
  // Store and protocol
  // ************************************************************
  localparam int STORE_BYTES = 16;
  localparam int STORE_AW = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] DEV_CODE = 4'ha;
  localparam logic [1:0] IDX_CTRL = 2'h0;
  localparam logic [1:0] IDX_WADDR = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_BUSY_MS = 4;
  localparam int WRITE_BUSY_CYCLES = WRITE_BUSY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BUSY_W = 19;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic scl;
    logic sda;
    logic [5:0] gp;
  } pmee_port_t;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_RX,
    PH_ACK,
    PH_TX,
    PH_MACK
  } pmee_phase_t;

endpackage

// ---- design/pmee_mem.sv ----
// Small byte memory for the serial data store, registered read data.
// Assumes one write port and one read port on the same clock.
`timescale 1ns/100ps
module pmee_mem
  import pmee_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [STORE_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [STORE_AW-1:0] raddr,
  output logic [7:0] rdata_q
);

  logic [7:0] mem_q [STORE_BYTES];

  // Array has no reset; contents are nonvolatile in spirit
  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  // Read data always from a register
  always_ff @(posedge clk) begin
    rdata_q <= mem_q[raddr];
  end

endmodule

// ---- tb/pmee_assertions.sv ----
// Checker: port relations of the two-wire port register block.
// Assumes binding to pmee_top and sight of its ports only.
`timescale 1ns/100ps
module pmee_assertions
  import pmee_pkg::*;
#(
  parameter logic [BUSY_W-1:0] BUSY_CYCLES = BUSY_W'(WRITE_BUSY_CYCLES)
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [7:0] reg_rdata_q,
  input wire logic scl_q,
  input wire logic sda_oe_n_q,
  input wire logic store_busy_q
);
  // ****
  // Relations
  // ****
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  logic wp;
  logic rp;
  int bcnt_q;
  // Strobes aimed at the port register
  assign wp = reg_we && reg_addr == PORT_DATA_ADDR;
  assign rp = reg_re && reg_addr == PORT_DATA_ADDR;
  // Busy run length; a timer that ends early or late shows as a count out of range
  always_ff @(posedge clk) begin
    if (srst || !store_busy_q) begin
      bcnt_q <= 0;
    end else begin
      bcnt_q <= bcnt_q + 1;
    end
  end
  property p_rst_idle;
    $fell(srst) |-> scl_q && sda_oe_n_q && !store_busy_q;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("lines not idle");
  property p_scl_wr;
    wp |=> scl_q == $past(reg_wdata[SCL_BIT]);
  endproperty
  a_scl_wr: assert property (p_scl_wr) else $error("clock bit");
  property p_sda_wr;
    wp |=> sda_oe_n_q == $past(reg_wdata[SDA_BIT]);
  endproperty
  a_sda_wr: assert property (p_sda_wr) else $error("data bit");
  property p_hold;
    !wp |=> $stable({scl_q, sda_oe_n_q});
  endproperty
  a_hold: assert property (p_hold) else $error("lines moved");
  property p_rd_idle;
    !reg_re |=> reg_rdata_q == READ_ZERO;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray data");
  property p_rd_other;
    reg_re && !rp |=> reg_rdata_q == READ_ZERO;
  endproperty
  a_rd_other: assert property (p_rd_other) else $error("unmapped");
  property p_rd_port;
    rp |=> reg_rdata_q[SCL_BIT] == $past(scl_q) && reg_rdata_q[5:0] == GP_READ;
  endproperty
  a_rd_port: assert property (p_rd_port) else $error("port read");
  property p_rd_pull;
    rp && !sda_oe_n_q |=> !reg_rdata_q[SDA_BIT];
  endproperty
  a_rd_pull: assert property (p_rd_pull) else $error("pull low");
  property p_busy;
    $fell(store_busy_q) |-> bcnt_q + 2 >= BUSY_CYCLES && bcnt_q <= BUSY_CYCLES + 1;
  endproperty
  a_busy: assert property (p_busy) else $error("busy length");
endmodule
bind pmee_top pmee_assertions #(.BUSY_CYCLES(BUSY_CYCLES)) i_chk (.clk(clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
  .reg_rdata_q(reg_rdata_q), .scl_q(scl_q), .sda_oe_n_q(sda_oe_n_q),
  .store_busy_q(store_busy_q));

// ---- tb/pmee_sw_model.sv ----
// Software model: bit-bangs the two lines through the port register.
// Assumes read data one cycle after the read strobe.
`timescale 1ns/100ps
module pmee_sw_model
  import pmee_pkg::*;
(
  input wire logic clk,
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  output logic reg_re,
  input wire logic [7:0] reg_rdata_q
);
  // ****
  // Register cycles and line phases
  // ****
  initial begin
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
  end
  task automatic wr(input logic [4:0] ad, input logic [7:0] v);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] ad, output logic [7:0] v);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_re <= 1'b0;
    @(posedge clk);
    v = reg_rdata_q;
  endtask
  // Eight cycles a phase around start and stop edges
  task automatic ln(input logic c, input logic d);
    wr(PORT_DATA_ADDR, {c, d, 6'h00});
    repeat (6) @(posedge clk);
  endtask
  task automatic start_c();
    ln(1'b1, 1'b1);
    ln(1'b1, 1'b0);
    ln(1'b0, 1'b0);
  endtask
  task automatic stop_c();
    ln(1'b0, 1'b0);
    ln(1'b1, 1'b0);
    ln(1'b1, 1'b1);
  endtask
  // Data move only under a low clock; sample while it is high.
  // Eight cycles low and eight high give the 160 ns line clock
  task automatic bit_c(input logic d, output logic q);
    logic [7:0] v;
    wr(PORT_DATA_ADDR, {1'b0, d, 6'h00});
    @(posedge clk);
    wr(PORT_DATA_ADDR, {1'b1, d, 6'h00});
    repeat (3) @(posedge clk);
    rd(PORT_DATA_ADDR, v);
    q = v[SDA_BIT];
    wr(PORT_DATA_ADDR, {1'b0, d, 6'h00});
    repeat (3) @(posedge clk);
  endtask
  // MSB first; a one releases the line so the store can answer
  task automatic xfer(input logic [7:0] tx, input logic fin, output logic [7:0] rx,
      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_c(tx[i], rx[i]);
    end
    bit_c(fin, ack);
  endtask
endmodule

// ---- tb/pmee_bench.sv ----
// Bench: software model drives the store; an integer model predicts it.
// Assumes pmee_pkg, pmee_top and the software partner model.
`timescale 1ns/100ps
`define CHK(nm, ex, sn) begin n_tests++; if ((sn) !== (ex)) begin err_total++; \
  $display("unexpected %s exp %h got %h", nm, ex, sn); end end
module pmee_bench
  import pmee_pkg::*;
;
  // Short busy time, still longer than one refused attempt
  localparam logic [BUSY_W-1:0] BC = 19'h0_0400;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_we;
  logic reg_re;
  logic [7:0] reg_rdata_q;
  logic scl_q;
  logic sda_oe_n_q;
  logic store_busy_q;
  logic [7:0] r;
  logic a;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  integer seed = 96910;
  int mem[16];
  pmee_top #(.BUSY_CYCLES(BC)) i_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_q(reg_rdata_q),
    .scl_q(scl_q), .sda_oe_n_q(sda_oe_n_q), .store_busy_q(store_busy_q));
  pmee_sw_model i_sw (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_q(reg_rdata_q));
  // ****
  // Tasks
  // ****
  always #5 clk = ~clk;
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Byte write, a refused attempt while busy, then wait it out
  task automatic put(input logic [3:0] ad, input logic [7:0] d);
    i_sw.start_c();
    i_sw.xfer({DEV_CODE, 4'h0}, 1'b1, r, a);
    `CHK("ctrl ack", 1'b0, a)
    i_sw.xfer({4'h0, ad}, 1'b1, r, a);
    `CHK("addr ack", 1'b0, a)
    i_sw.xfer(d, 1'b1, r, a);
    `CHK("data ack", 1'b0, a)
    i_sw.stop_c();
    mem[ad] = d;
    repeat (8) @(posedge clk);
    `CHK("busy", 1'b1, store_busy_q)
    i_sw.start_c();
    i_sw.xfer({DEV_CODE, 4'h0}, 1'b1, r, a);
    `CHK("busy ack", 1'b1, a)
    i_sw.stop_c();
    for (int i = 0; i < 1100 && store_busy_q !== 1'b0; i++) @(posedge clk);
    `CHK("busy end", 1'b0, store_busy_q)
  endtask
  // Random read with restart; the stream wraps past the top byte
  task automatic get(input logic [3:0] ad, input int n);
    i_sw.start_c();
    i_sw.xfer({DEV_CODE, 4'h0}, 1'b1, r, a);
    `CHK("rd ctrl ack", 1'b0, a)
    i_sw.xfer({4'h0, ad}, 1'b1, r, a);
    `CHK("rd addr ack", 1'b0, a)
    i_sw.start_c();
    i_sw.xfer({DEV_CODE, 4'h1}, 1'b1, r, a);
    `CHK("read ack", 1'b0, a)
    for (int k = 0; k < n; k++) begin
      i_sw.xfer(8'hFF, k == n - 1, r, a);
      `CHK("rd byte", 8'(mem[(ad + k) % 16]), r)
    end
    i_sw.stop_c();
  endtask
  // A hang ends the run; the full run needs well under this
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    i_sw.rd(PORT_DATA_ADDR, r);
    `CHK("port rst", 8'hC0, r)
    i_sw.wr(5'h07, 8'h00);
    i_sw.rd(5'h07, r);
    `CHK("unmapped", 8'h00, r)
    i_sw.wr(PORT_DATA_ADDR, 8'h40);
    i_sw.rd(PORT_DATA_ADDR, r);
    `CHK("port 40", 8'h40, r)
    i_sw.wr(PORT_DATA_ADDR, 8'h00);
    i_sw.rd(PORT_DATA_ADDR, r);
    `CHK("port 00", 8'h00, r)
    i_sw.ln(1'b0, 1'b1);
    i_sw.ln(1'b1, 1'b1);
    i_sw.start_c();
    i_sw.xfer(8'h50, 1'b1, r, a);
    `CHK("bad code", 1'b1, a)
    i_sw.stop_c();
    for (int j = 0; j < 3; j++) begin
      put(4'((j * 15) % 16), 8'($random(seed)));
    end
    get(4'hE, 3);
    close_out();
  end
endmodule
